// ==== oda_pkg.sv ====
`default_nettype none
package oda_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int STOP_DLY_NS = 100_000;
    // Strictly longer than the stop delay, so one cycle is added
    localparam int STOP_CYC = (STOP_DLY_NS * CLK_PER_US) / 1000 + 1;
    localparam int FALL_DLY_NS = 25_000;
    localparam int FALL_CYC = (FALL_DLY_NS * CLK_PER_US + 999) / 1000;
    localparam int PRE_CYC = 18;
    localparam int TMR_W = 12;
    localparam int CNT_W = 9;
    localparam logic [5:0] RDIV_MIN = 6'h02;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_OUT0 = 8'h08;
    localparam int OUT_STRIDE = 4;
    localparam int C_RAO = 0;
    localparam int C_SW = 1;
    localparam int F_FALL = 7;
    localparam int F_RISE = 6;
    localparam int S_BUSY = 8;
    localparam int S_PIN = 9;
    localparam int S_ST_LSB = 16;
    localparam int CFG_W = 13;
    localparam logic [1:0] PWR_RUN = 2'h0;
    localparam logic [1:0] PWR_CALMUTE = 2'h1;
    localparam logic [1:0] PWR_BUF_OFF = 2'h2;
    localparam logic [1:0] PWR_ALL_OFF = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic align_en;
        logic [1:0] power;
        logic force_low;
        logic polarity;
        logic [7:0] offset;
    } oda_cfg_t;
    localparam oda_cfg_t CFG_RST = '{align_en: 1'b1, power: PWR_CALMUTE,
        force_low: 1'b0, polarity: 1'b0, offset: 8'h00};
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_STOP = 7'b0000010,
        ST_HOLD = 7'b0000100,
        ST_FALL = 7'b0001000,
        ST_FB = 7'b0010000,
        ST_PRE = 7'b0100000,
        ST_OFS = 7'b1000000
    } oda_state_t;
endpackage : oda_pkg
`default_nettype wire

// ==== oda_align.sv ====
// The AXI4-Lite interface to the registers and the address map were decided locally.
`default_nettype none
module oda_align
    import oda_pkg::*;
#(
    parameter int N_OUT = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Alignment request and timing events
    input wire logic align_pin,
    input wire logic presc_tick,
    input wire logic fb_tick,
    input wire logic ref_tick,
    input wire logic rdiv_tick,
    input wire logic [5:0] rdiv_ratio,
    // Divider side
    input wire logic [N_OUT-1:0] div_clk,
    input wire logic [N_OUT-1:0] ratio_change,
    input wire logic vco_cal_active,
    // Output drive
    output logic [N_OUT-1:0] out_true,
    output logic [N_OUT-1:0] out_comp,
    output logic [N_OUT-1:0] div_run,
    output logic [N_OUT-1:0] buf_on,
    output logic bias0_on,
    output logic rdiv_retime
);
    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (N_OUT < 1 || N_OUT > 8) begin : g_bad_n
        $error("N_OUT must lie between 1 and 8");
    end

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Output config window hit, index in low bits
    function automatic logic [3:0] out_sel(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - ADDR_OUT0;
        out_sel = 4'h0;
        if (a >= ADDR_OUT0 && rel[1:0] == 2'h0 &&
            rel[7:2] < 6'(N_OUT)) begin
            out_sel = {1'b1, rel[4:2]};
        end
    endfunction : out_sel

    // Byte-lane merge of write data
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : merge

    // ************************************************************
    // Registers and state
    // ************************************************************
    oda_cfg_t cfg_q [N_OUT];
    oda_state_t st_q;
    logic rao_q, sw_q, aw_v_q, w_v_q, bvalid_q, rvalid_q;
    logic [7:0] aw_q;
    logic [31:0] w_q, rdata_q;
    logic [3:0] ws_q;
    logic [1:0] bresp_q, rresp_q;
    logic [TMR_W-1:0] tmr_q;
    logic [CNT_W-1:0] cnt_q;
    logic [N_OUT-1:0] part_q, stop_q, aligned_q, true_q, comp_q;
    logic [7:0] ofs_q [N_OUT];
    logic pin_s1_q, pin_s2_q, pin_ref_q, req_q, pin_lvl_q, rdiv_ret_q;

    logic fall_mode, rise_mode, ref_mode, sw_eff, pin_lvl, req, wr_go;
    logic [3:0] wsel, rsel;
    logic [31:0] ctrl_rd, wr_ctrl;
    logic [N_OUT-1:0] part_d, restart;
    logic rdiv_target;

    // Edge controls share offset-0 bits in reference mode
    assign fall_mode = rao_q & cfg_q[0].offset[F_FALL];
    assign rise_mode = rao_q & cfg_q[0].offset[F_RISE];
    assign ref_mode = fall_mode | rise_mode;
    assign sw_eff = sw_q & ~ref_mode;
    assign pin_lvl = ref_mode ? pin_ref_q : pin_s2_q;
    assign req = pin_lvl | sw_eff;
    assign rdiv_target = fall_mode & rise_mode &
        (rdiv_ratio >= RDIV_MIN);

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    assign s_axi_awready = ~aw_v_q & ~bvalid_q;
    assign s_axi_wready = ~w_v_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wr_go = aw_v_q & w_v_q & ~bvalid_q;
    assign wsel = out_sel(aw_q);
    assign rsel = out_sel(s_axi_araddr);
    assign ctrl_rd = {30'h0, sw_q, rao_q};
    assign wr_ctrl = merge(ctrl_rd, w_q, ws_q);

    // Address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_q <= 1'b0;
            aw_q <= 8'h00;
            w_v_q <= 1'b0;
            w_q <= 32'h0;
            ws_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_v_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_v_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_v_q <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_v_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_q == ADDR_CTRL || wsel[3]) ? RESP_OKAY
                : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rao_q <= 1'b0;
            sw_q <= 1'b0;
        end else if (wr_go && aw_q == ADDR_CTRL) begin
            rao_q <= wr_ctrl[C_RAO];
            sw_q <= wr_ctrl[C_SW];
        end
    end

    // Per-output configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_OUT; i++) begin
                cfg_q[i] <= CFG_RST;
            end
        end else if (wr_go && wsel[3]) begin
            cfg_q[wsel[2:0]] <= CFG_W'(merge(32'(cfg_q[wsel[2:0]]),
                w_q, ws_q));
        end
    end

    // Read path, one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            if (s_axi_araddr == ADDR_CTRL) begin
                rdata_q <= ctrl_rd;
            end else if (s_axi_araddr == ADDR_STAT) begin
                rdata_q <= 32'(aligned_q);
                rdata_q[S_BUSY] <= (st_q != ST_IDLE);
                rdata_q[S_PIN] <= pin_lvl;
                rdata_q[S_ST_LSB +: 7] <= st_q;
            end else if (rsel[3]) begin
                rdata_q <= 32'(cfg_q[rsel[2:0]]);
            end else begin
                rdata_q <= 32'h0;
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // Request capture
    // ************************************************************
    // Two-stage pin synchroniser, reference-tick sample in edge modes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_ref_q <= 1'b0;
        end else begin
            pin_s1_q <= align_pin;
            pin_s2_q <= pin_s1_q;
            if (ref_tick) begin
                pin_ref_q <= pin_s2_q;
            end
        end
    end

    // Request history and reference divider retime pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
            pin_lvl_q <= 1'b0;
            rdiv_ret_q <= 1'b0;
        end else begin
            req_q <= req;
            pin_lvl_q <= pin_lvl;
            rdiv_ret_q <= rise_mode & pin_lvl & ~pin_lvl_q &
                (rdiv_ratio >= RDIV_MIN);
        end
    end
    assign rdiv_retime = rdiv_ret_q;

    // ************************************************************
    // Alignment sequencer
    // ************************************************************
    // Participants: own enable, divider 0 dropped in reference mode
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            part_d[i] = cfg_q[i].align_en;
        end
        part_d[0] = cfg_q[0].align_en & ~rao_q;
    end

    // Outputs whose start offset has been reached
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            restart[i] = (st_q == ST_OFS) && part_q[i] && stop_q[i] &&
                (cnt_q == CNT_W'(ofs_q[i]));
        end
    end

    // Sequence state, timers and counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            tmr_q <= '0;
            cnt_q <= '0;
            part_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    tmr_q <= '0;
                    if (req && !req_q) begin
                        part_q <= part_d;
                        st_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == TMR_W'(STOP_CYC - 1)) begin
                        tmr_q <= '0;
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (!req) begin
                        st_q <= fall_mode ? ST_FB : ST_FALL;
                    end
                end
                ST_FALL: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == TMR_W'(FALL_CYC - 1)) begin
                        st_q <= ST_FB;
                    end
                end
                ST_FB: begin
                    cnt_q <= '0;
                    if (rdiv_target ? rdiv_tick : fb_tick) begin
                        st_q <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (presc_tick) begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == CNT_W'(PRE_CYC - 1)) begin
                            cnt_q <= '0;
                            st_q <= ST_OFS;
                        end
                    end
                end
                ST_OFS: begin
                    if ((stop_q & part_q & ~restart) == '0) begin
                        st_q <= ST_IDLE;
                    end else if (presc_tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Offsets latched when retiming starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_OUT; i++) begin
                ofs_q[i] <= 8'h00;
            end
        end else if (st_q == ST_FB) begin
            for (int i = 0; i < N_OUT; i++) begin
                ofs_q[i] <= cfg_q[i].offset;
            end
        end
    end

    // Stop flags: set after the stop delay, cleared at restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_q <= '0;
        end else if (st_q == ST_STOP &&
            tmr_q == TMR_W'(STOP_CYC - 1)) begin
            stop_q <= part_q;
        end else begin
            stop_q <= stop_q & ~restart;
        end
    end

    // Aligned flags: completion wins over a same-cycle ratio change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aligned_q <= '0;
        end else if (st_q == ST_IDLE && req && !req_q) begin
            aligned_q <= aligned_q & ~part_d & ~ratio_change;
        end else begin
            aligned_q <= (aligned_q & ~ratio_change) | restart;
        end
    end

    // ************************************************************
    // Output drive
    // ************************************************************
    for (genvar g = 0; g < N_OUT; g++) begin : g_out
        logic hold_low;
        logic pwr_dn_cal;
        // Calibration mute in value 1; output 0 in reference mode also powers down
        assign pwr_dn_cal = (g == 0) && rao_q && vco_cal_active &&
            cfg_q[g].power == PWR_CALMUTE;
        assign hold_low = cfg_q[g].force_low | stop_q[g] |
            (vco_cal_active && cfg_q[g].power == PWR_CALMUTE);
        // Registered true and complement sides
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                true_q[g] <= 1'b0;
                comp_q[g] <= 1'b1;
            end else if (hold_low) begin
                true_q[g] <= cfg_q[g].polarity;
                comp_q[g] <= ~cfg_q[g].polarity;
            end else begin
                true_q[g] <= div_clk[g] ^ cfg_q[g].polarity;
                comp_q[g] <= ~(div_clk[g] ^ cfg_q[g].polarity);
            end
        end
        // Buffer off for values 2 and 3, divider only for 3
        assign buf_on[g] = (cfg_q[g].power != PWR_BUF_OFF) &&
            (cfg_q[g].power != PWR_ALL_OFF) && !pwr_dn_cal;
        assign div_run[g] = (cfg_q[g].power != PWR_ALL_OFF) &&
            !stop_q[g];
    end
    assign out_true = true_q;
    assign out_comp = comp_q;
    // Bias of output 0 removed by force-low in reference mode
    assign bias0_on = ~(rao_q & cfg_q[0].force_low);
endmodule : oda_align
`default_nettype wire

// ==== oda_props.sv ====
`default_nettype none
// ************************************************************
// Port checker for the alignment block
// ************************************************************
module oda_props
    import oda_pkg::*;
#(
    parameter int N_OUT = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Alignment request and outputs
    input wire logic align_pin,
    input wire logic [5:0] rdiv_ratio,
    input wire logic rdiv_retime,
    input wire logic [N_OUT-1:0] out_true,
    input wire logic [N_OUT-1:0] out_comp,
    input wire logic [N_OUT-1:0] div_run
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [11:0] hi_cnt_q;
    // Cycles the request pin has stayed high, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn || !align_pin) begin
            hi_cnt_q <= 12'h000;
        end else if (hi_cnt_q != 12'hFFF) begin
            hi_cnt_q <= hi_cnt_q + 12'h001;
        end
    end
    // No divider stops within the first 2500 cycles of a request
    stop_early_a: assert property (
        hi_cnt_q > 12'h000 && hi_cnt_q <= 12'h9C4 && !s_axi_bvalid
        |-> (div_run | ~$past(div_run)) == '1)
        else $error("output stopped too soon");
    sides_comp_a: assert property (out_comp == ~out_true)
        else $error("output sides not complementary");
    retime_pulse_a: assert property (rdiv_retime |=> !rdiv_retime)
        else $error("retime pulse too long");
    retime_ratio_a: assert property (
        rdiv_retime |-> rdiv_ratio >= RDIV_MIN)
        else $error("retime with ratio below two");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    b_release_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    r_release_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule : oda_props
bind oda_align oda_props #(.N_OUT(N_OUT)) i_props (.*);
`default_nettype wire

// ==== oda_ctl_model.sv ====
`default_nettype none
// ************************************************************
// System controller and divider event model
// ************************************************************
module oda_ctl_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request from the bench
    input wire logic go,
    // Pin and event outputs
    output logic align_pin,
    output logic presc_tick,
    output logic fb_tick,
    output logic ref_tick,
    output logic rdiv_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reference every 2 cycles, ratio 2: R*ceil(12500/R)+1 periods
    localparam int HOLD = 2 * (2 * ((12500 + 1) / 2) + 1);
    logic [15:0] cyc_q;
    logic [15:0] hold_q;
    // Free-running timebase for all divider events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_q <= 16'h0000;
        end else begin
            cyc_q <= cyc_q + 16'h0001;
        end
    end
    // Event pulses of one cycle each
    assign presc_tick = cyc_q[1:0] == 2'h3;
    assign ref_tick = cyc_q[0];
    assign rdiv_tick = cyc_q[2:0] == 3'h7;
    assign fb_tick = cyc_q[3:0] == 4'hF;
    // Pin moves only with a reference event and stays up over 1 ms
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            align_pin <= 1'b0;
            hold_q <= 16'h0000;
        end else if (align_pin) begin
            hold_q <= hold_q + 16'h0001;
            if (ref_tick && hold_q >= 16'(HOLD - 1)) begin
                align_pin <= 1'b0;
            end
        end else if (ref_tick && go) begin
            align_pin <= 1'b1;
            hold_q <= 16'h0000;
        end
    end
endmodule : oda_ctl_model
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
`define CHK(nm, e, g) \
    begin checks++; \
    if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ************************************************************
// Self-checking bench
// ************************************************************
module tb_top;
    import oda_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, go, vco_cal_active, bias0_on, rdiv_retime;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic align_pin, presc_tick, fb_tick, ref_tick, rdiv_tick;
    logic [5:0] rdiv_ratio;
    logic [4:0] div_clk, ratio_change, out_true, out_comp, div_run, buf_on;
    int fails = 0, checks = 0, cyc = 0, n_ret = 0, n;
    oda_align #(.N_OUT(5)) i_dut (.*);
    oda_ctl_model i_ctl (.*);
    // Clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Retime pulse counter and hang guard
    always @(posedge aclk) begin
        if (rdiv_retime === 1'b1) n_ret++;
        cyc++;
        if (cyc == 80000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report;
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    function automatic logic [7:0] oa(input int i);
        return ADDR_OUT0 + 8'(OUT_STRIDE * i);
    endfunction : oa
    function automatic logic [31:0] cfg(input logic al, input logic [1:0] pw,
        input logic fl, input logic pl, input logic [7:0] of);
        return {19'h00000, al, pw, fl, pl, of};
    endfunction : cfg
    // Bus write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask : wr
    // Bus read
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic rk(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic [1:0] er);
        axr(a, d, r);
        `CHK("rdata", e, d & m)
        `CHK("rresp", er, r)
    endtask : rk
    task automatic idle_wait;
        do axr(ADDR_STAT, d, r); while (d[S_BUSY] !== 1'b0);
    endtask : idle_wait
    // Main sequence
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, go} = '0;
        {s_axi_arvalid, s_axi_rready, vco_cal_active} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {div_clk, ratio_change} = '0;
        s_axi_wstrb = 4'hF;
        rdiv_ratio = 6'h02;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rk(ADDR_CTRL, 32'h0, '1, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            rk(oa(i), 32'h1400, '1, RESP_OKAY);
        end
        rk(ADDR_STAT, 32'h0001_0000, '1, RESP_OKAY);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        wr(8'h0A, 32'h1, RESP_SLVERR);
        rk(8'h1C, 32'h0, '1, RESP_SLVERR);
        // Polarity, force-low, power and calibration mute per output
        div_clk <= 5'h1F;
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 4; k++) begin
                wr(oa(i), cfg(1'b1, PWR_RUN, k[1], k[0], 8'h00), RESP_OKAY);
                repeat (4) @(posedge aclk);
                `CHK("out_true", k[1] ? k[0] : !k[0], out_true[i])
                wr(oa(i), cfg(1'b1, 2'(k), 1'b0, 1'b0, 8'h00), RESP_OKAY);
                `CHK("buf_on", k < 2, buf_on[i])
                `CHK("div_run", k != 3, div_run[i])
            end
            vco_cal_active <= 1'b1;
            wr(oa(i), cfg(1'b1, PWR_CALMUTE, 1'b0, 1'b0, 8'h00), RESP_OKAY);
            repeat (4) @(posedge aclk);
            `CHK("cal mute", 1'b0, out_true[i])
            vco_cal_active <= 1'b0;
            wr(oa(i), cfg(1'b1, PWR_RUN, 1'b0, 1'b0, 8'h00), RESP_OKAY);
        end
        // Reference mode: bias cut and software trigger gated
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        wr(oa(0), cfg(1'b0, PWR_RUN, 1'b1, 1'b0, 8'h00), RESP_OKAY);
        `CHK("bias0_on", 1'b0, bias0_on)
        wr(oa(0), 32'h0000_0080, RESP_OKAY);
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        rk(ADDR_STAT, 32'h0, 32'h100, RESP_OKAY);
        // Pin alignment with rising-edge retime of the reference divider
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        wr(oa(0), 32'h0000_1040, RESP_OKAY);
        go <= 1'b1;
        @(posedge align_pin);
        go <= 1'b0;
        repeat (2700) @(posedge aclk);
        `CHK("div_run", 5'h01, div_run)
        @(negedge align_pin);
        idle_wait();
        `CHK("retimes", 1, n_ret)
        rk(ADDR_STAT, 32'h1E, 32'h1F, RESP_OKAY);
        ratio_change <= 5'h02;
        @(posedge aclk);
        ratio_change <= 5'h00;
        rk(ADDR_STAT, 32'h1C, 32'h1F, RESP_OKAY);
        // Software alignment with start offsets, output 4 excluded
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wr(oa(0), cfg(1'b1, PWR_RUN, 1'b0, 1'b1, 8'h00), RESP_OKAY);
        wr(oa(1), cfg(1'b1, PWR_RUN, 1'b0, 1'b0, 8'h03), RESP_OKAY);
        wr(oa(2), cfg(1'b1, PWR_RUN, 1'b0, 1'b0, 8'h03), RESP_OKAY);
        wr(oa(4), cfg(1'b0, PWR_RUN, 1'b0, 1'b0, 8'h00), RESP_OKAY);
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        rk(ADDR_STAT, 32'h0002_0100, 32'h007F_0100, RESP_OKAY);
        repeat (2300) @(posedge aclk);
        `CHK("div_run", 5'h1F, div_run)
        repeat (300) @(posedge aclk);
        `CHK("div_run", 5'h10, div_run)
        `CHK("stopped", 4'h1, out_true[3:0])
        repeat (22500) @(posedge aclk);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        repeat (600) @(posedge aclk);
        `CHK("div_run", 5'h10, div_run)
        n = 600;
        while (div_run[3] !== 1'b1) begin
            @(posedge aclk);
            n++;
        end
        `CHK("restart", 1'b1, n >= 690 && n <= 720)
        `CHK("div_run", 5'h19, div_run)
        n = 0;
        while (div_run[1] !== 1'b1) begin
            @(posedge aclk);
            n++;
        end
        `CHK("offset gap", 12, n)
        `CHK("div_run", 5'h1F, div_run)
        idle_wait();
        rk(ADDR_STAT, 32'h0001_000F, 32'h007F_010F, RESP_OKAY);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
